// >>> hdl/ddr_cmd_regs.vh
`ifndef DDR_CMD_REGS_VH
`define DDR_CMD_REGS_VH
// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MODE 8'h08
`define ADDR_EXT_MODE 8'h0C
`define ADDR_REF_CNT 8'h10
`define ADDR_TIMING 8'h14
`define ADDR_DATA 8'h18
// control fields
`define CTRL_BL_LSB 0
`define CTRL_CL_LSB 4
`define CTRL_RESET 8'h22
// cas latency codes, half clocks
`define CL_2 3'h4
`define CL_25 3'h5
`define CL_3 3'h6
// timing counts, cycles
`define T_RAS_RST 4'h6
`define T_XSNR_RST 8'hC8
`define T_DLL_CYC 8'hC8
// command encodings {cs,ras,cas,we}
`define CMD_NOP 4'h7
`define CMD_ACT 4'h3
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define CMD_BST 4'h6
`define CMD_PRE 4'h2
`define CMD_REF 4'h1
`define CMD_MRS 4'h0
`endif

// >>> hdl/link_sync.v
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire mclk,
    input wire srst,
    // async in, filtered out
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    always @(posedge mclk) begin
        if (srst) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                dout <= s3_ff;
            end
        end
    end
endmodule // link_sync
`default_nettype wire

// >>> hdl/ddr_cmd_device.v
// Notes on behaviour
// - command decoded from cs ras cas we
// - deselect and nop do nothing
// - auto precharge sampled per access
// - precharge bit selects one or all banks
// - auto precharge closes after read burst, row_active_min_time met
// - burst stop truncates latest plain read
// - refresh uses internal counter address
// - refresh with clock enable low: self refresh
// - mode load selects base or extended
// - write mask high skips the element
// - data follows cas latency each edge
// - strobe preamble, no postamble; strobe released with the data
// - new read cuts the burst, data restarts after cas latency
// - burst stop latency equals cas latency
// - cas latency 2, 2.5 or 3
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_cmd_regs.vh"
module ddr_cmd_device (
    // system
    input wire mclk,
    input wire srst,
    // memory link, sampled by mclk
    input wire link_ck,
    input wire link_cke,
    input wire link_cs_n,
    input wire link_ras_n,
    input wire link_cas_n,
    input wire link_we_n,
    input wire bank_addr_bit0,
    input wire bank_addr_bit1,
    input wire [12:0] link_addr,
    input wire write_mask,
    input wire [7:0] link_dq_in,
    output reg [7:0] link_dq_out,
    output reg link_dq_oe,
    output reg link_dqs_out,
    output reg link_dqs_oe,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    wire [20:0] sync_in = {link_ck, link_cke, link_cs_n, link_ras_n, link_cas_n, link_we_n,
        bank_addr_bit1, bank_addr_bit0, link_addr};
    wire [20:0] sync_out;
    link_sync #(.W(21)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .din(sync_in),
        .dout(sync_out)
    );
    wire ck_s = sync_out[20];
    wire cke_s = sync_out[19];
    wire [3:0] cmd_s = sync_out[18:15];
    wire [1:0] ba_s = sync_out[14:13];
    wire [12:0] a_s = sync_out[12:0];
    // link-clock edge detection
    reg ck_d_ff;
    reg cke_d_ff;
    always @(posedge mclk) begin
        if (srst) begin
            ck_d_ff <= 1'b0;
        end else begin
            ck_d_ff <= ck_s;
        end
    end
    wire ck_rise = ck_s & ~ck_d_ff;
    wire ck_fall = ~ck_s & ck_d_ff;
    // registers
    reg [7:0] ctrl_ff;
    reg [12:0] mode_ff;
    reg [12:0] ext_mode_ff;
    reg [12:0] ref_cnt_ff;
    reg [3:0] t_ras_ff;
    reg [7:0] t_xsnr_ff;
    reg [7:0] data_pat_ff;
    reg self_ref_ff;
    reg dll_off_ff;
    reg [7:0] exit_cnt_ff;
    reg [3:0] open_ff;
    reg [3:0] ras_cnt_ff [0:3];
    reg [3:0] ap_pend_ff;
    reg [7:0] mask_cnt_ff;
    reg [7:0] wr_cnt_ff;
    reg [7:0] wdata_ff;
    // read burst state in half-clock units
    reg [2:0] lat_ff;
    reg [3:0] rem_ff;
    reg rd_ap_ff;
    reg [1:0] rd_bank_ff;
    reg [2:0] stop_lat_ff;
    reg stop_pend_ff;
    reg [3:0] burst_len;
    always @* begin
        case (mode_ff[2:0])
            3'h1: burst_len = 4'h4;
            3'h2: burst_len = 4'h8;
            3'h3: burst_len = 4'hF;
            default: burst_len = 4'h2;
        endcase
    end
    // cas latency 2, 2.5 or 3
    wire [2:0] cl_half = (mode_ff[6:4] == 3'h2) ? `CL_2 :
        (mode_ff[6:4] == 3'h6) ? `CL_25 : `CL_3;
    // deselect and nop decode to nothing
    wire cmd_ok = ck_rise & cke_s & ~self_ref_ff & ~cmd_s[3];
    wire is_act = cmd_ok & (cmd_s == `CMD_ACT);
    wire is_rd = cmd_ok & (cmd_s == `CMD_RD);
    wire is_wr = cmd_ok & (cmd_s == `CMD_WR);
    wire is_bst = cmd_ok & (cmd_s == `CMD_BST);
    wire is_pre = cmd_ok & (cmd_s == `CMD_PRE);
    wire is_mrs = cmd_ok & (cmd_s == `CMD_MRS);
    wire ref_cmd = ck_rise & ~self_ref_ff & ~cmd_s[3] & (cmd_s == `CMD_REF);
    // refresh with falling cke enters self refresh
    wire sr_entry = ref_cmd & ~cke_s & cke_d_ff;
    wire is_ref = ref_cmd & cke_s;
    integer i;
    always @(posedge mclk) begin
        if (srst) begin
            cke_d_ff <= 1'b0;
            mode_ff <= 13'h0000;
            ext_mode_ff <= 13'h0000;
            ref_cnt_ff <= 13'h0000;
            self_ref_ff <= 1'b0;
            dll_off_ff <= 1'b0;
            exit_cnt_ff <= 8'h00;
            open_ff <= 4'h0;
            ap_pend_ff <= 4'h0;
            mask_cnt_ff <= 8'h00;
            wr_cnt_ff <= 8'h00;
            wdata_ff <= 8'h00;
            for (i = 0; i < 4; i = i + 1) begin
                ras_cnt_ff[i] <= 4'h0;
            end
        end else begin
            if (ck_rise) begin
                cke_d_ff <= cke_s;
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (ck_rise && ras_cnt_ff[i] != 4'h0) begin
                    ras_cnt_ff[i] <= ras_cnt_ff[i] - 4'h1;
                end
            end
            if (is_ref || sr_entry) begin
                ref_cnt_ff <= ref_cnt_ff + 13'h0001;
            end
            if (sr_entry) begin
                self_ref_ff <= 1'b1;
                dll_off_ff <= 1'b1;
            end else if (self_ref_ff && ck_rise && cke_s) begin
                self_ref_ff <= 1'b0;
                exit_cnt_ff <= t_xsnr_ff;
            end else if (ck_rise && exit_cnt_ff != 8'h00) begin
                exit_cnt_ff <= exit_cnt_ff - 8'h01;
                if (exit_cnt_ff == 8'h01) begin
                    dll_off_ff <= 1'b0;
                end
            end
            if (is_act) begin
                open_ff[ba_s] <= 1'b1;
                ras_cnt_ff[ba_s] <= t_ras_ff;
            end
            if (is_pre) begin
                if (a_s[10]) begin
                    open_ff <= 4'h0;
                end else begin
                    open_ff[ba_s] <= 1'b0;
                end
            end
            if ((is_rd || is_wr) && a_s[10]) begin
                ap_pend_ff[ba_s] <= 1'b1;
            end
            // close after read burst once row_active_min_time met
            for (i = 0; i < 4; i = i + 1) begin
                if (ap_pend_ff[i] && ras_cnt_ff[i] == 4'h0 &&
                        !((is_rd || is_wr) && ba_s == i[1:0]) &&
                        !(rem_ff != 4'h0 && rd_bank_ff == i[1:0])) begin
                    open_ff[i] <= 1'b0;
                    ap_pend_ff[i] <= 1'b0;
                end
            end
            if (is_mrs && ba_s == 2'h0) begin
                mode_ff <= a_s;
            end else if (is_mrs && ba_s == 2'h1) begin
                ext_mode_ff <= a_s;
            end
            if (is_wr) begin
                wr_cnt_ff <= wr_cnt_ff + 8'h01;
            end
            if (ck_rise && wr_cnt_ff != 8'h00) begin
                if (write_mask) begin
                    mask_cnt_ff <= mask_cnt_ff + 8'h01;
                end else begin
                    wdata_ff <= link_dq_in;
                end
            end
        end
    end
    // read pipeline on both clock edges
    wire hedge = ck_rise | ck_fall;
    wire [2:0] rd_lat = cl_half - 3'h1;
    always @(posedge mclk) begin
        if (srst) begin
            lat_ff <= 3'h0;
            rem_ff <= 4'h0;
            rd_ap_ff <= 1'b0;
            rd_bank_ff <= 2'h0;
            stop_lat_ff <= 3'h0;
            stop_pend_ff <= 1'b0;
            link_dq_out <= 8'h00;
            link_dq_oe <= 1'b0;
            link_dqs_out <= 1'b0;
            link_dqs_oe <= 1'b0;
        end else begin
            if (is_rd) begin
                lat_ff <= rd_lat;
                rem_ff <= burst_len;
                rd_ap_ff <= a_s[10];
                rd_bank_ff <= ba_s;
            end else if (hedge) begin
                if (lat_ff != 3'h0) begin
                    lat_ff <= lat_ff - 3'h1;
                end else if (rem_ff != 4'h0) begin
                    rem_ff <= rem_ff - 4'h1;
                end
            end
            // stop latest read lacking auto precharge
            if (is_bst && !rd_ap_ff && rem_ff != 4'h0) begin
                stop_pend_ff <= 1'b1;
                stop_lat_ff <= rd_lat;
            end else if (stop_pend_ff && hedge) begin
                // stop takes effect after cas latency
                if (stop_lat_ff == 3'h0) begin
                    stop_pend_ff <= 1'b0;
                    rem_ff <= 4'h0;
                end else begin
                    stop_lat_ff <= stop_lat_ff - 3'h1;
                end
            end
            if (hedge) begin
                if (lat_ff == 3'h1 && rem_ff != 4'h0 && !is_rd) begin
                    link_dqs_oe <= 1'b1;
                    link_dqs_out <= 1'b0;
                    link_dq_oe <= 1'b0;
                end else if (lat_ff == 3'h0 && rem_ff != 4'h0 &&
                        !(stop_pend_ff && stop_lat_ff == 3'h0)) begin
                    link_dq_oe <= 1'b1;
                    link_dqs_oe <= 1'b1;
                    link_dqs_out <= ck_rise;
                    link_dq_out <= data_pat_ff ^ {4'h0, rem_ff};
                end else begin
                    link_dq_oe <= 1'b0;
                    link_dqs_oe <= 1'b0;
                    link_dqs_out <= 1'b0;
                end
            end
        end
    end
    // axi4-lite slave
    reg [7:0] aw_ff;
    reg aw_have_ff;
    reg [31:0] w_ff;
    reg w_have_ff;
    always @(posedge mclk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_ff <= 8'h00;
            aw_have_ff <= 1'b0;
            w_ff <= 32'h0000_0000;
            w_have_ff <= 1'b0;
            ctrl_ff <= `CTRL_RESET;
            t_ras_ff <= `T_RAS_RST;
            t_xsnr_ff <= `T_XSNR_RST;
            data_pat_ff <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= s_axi_awaddr;
                aw_have_ff <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= s_axi_wdata;
                w_have_ff <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_ff)
                    `ADDR_CTRL: ctrl_ff <= w_ff[7:0];
                    `ADDR_TIMING: begin
                        t_ras_ff <= w_ff[3:0];
                        t_xsnr_ff <= w_ff[15:8];
                    end
                    `ADDR_DATA: data_pat_ff <= w_ff[7:0];
                    `ADDR_STATUS, `ADDR_MODE, `ADDR_EXT_MODE, `ADDR_REF_CNT: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    always @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl_ff};
                `ADDR_STATUS: s_axi_rdata <= {14'h0000, mask_cnt_ff, open_ff, ap_pend_ff,
                    dll_off_ff, self_ref_ff};
                `ADDR_MODE: s_axi_rdata <= {19'h00000, mode_ff};
                `ADDR_EXT_MODE: s_axi_rdata <= {19'h00000, ext_mode_ff};
                `ADDR_REF_CNT: s_axi_rdata <= {19'h00000, ref_cnt_ff};
                `ADDR_TIMING: s_axi_rdata <= {16'h0000, t_xsnr_ff, 4'h0, t_ras_ff};
                `ADDR_DATA: s_axi_rdata <= {wr_cnt_ff, wdata_ff, 8'h00, data_pat_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // ddr_cmd_device
`default_nettype wire

// >>> tb/ddr_cmd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_checker (
    // clock and reset
    input wire mclk,
    input wire srst,
    // read return on the link
    input wire link_dq_oe,
    input wire link_dqs_out,
    input wire link_dqs_oe,
    // register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    reset_quiet_a: assert property ($fell(srst) |-> !link_dq_oe && !link_dqs_oe && !s_axi_bvalid)
        else $error("output active after reset");
    bresp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after handshake");
    rresp_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after handshake");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    strobe_data_a: assert property (link_dq_oe |-> link_dqs_oe)
        else $error("data driven without strobe");
    preamble_low_a: assert property ($rose(link_dqs_oe) |-> !link_dqs_out ##1 link_dqs_oe)
        else $error("strobe preamble not low");
    preamble_lead_a: assert property ($rose(link_dq_oe) |-> $past(link_dqs_oe))
        else $error("data before strobe preamble");

    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(link_dq_oe));
endmodule // ddr_cmd_checker

bind ddr_cmd_device ddr_cmd_checker u_chk (
    .mclk(mclk), .srst(srst), .link_dq_oe(link_dq_oe), .link_dqs_out(link_dqs_out), .link_dqs_oe(link_dqs_oe),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// >>> tb/ddr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_cmd_regs.vh"
module ddr_ctl_model (
    // memory clock and command
    output logic link_ck,
    output logic link_cke,
    output logic link_cs_n,
    output logic link_ras_n,
    output logic link_cas_n,
    output logic link_we_n,
    // address, mask, released data
    output logic [1:0] bank,
    output logic [12:0] link_addr,
    output logic write_mask,
    output logic [7:0] ctl_dq
);
    initial begin
        link_ck = 1'b0;
        link_cke = 1'b1;
        {link_cs_n, link_ras_n, link_cas_n, link_we_n} = `CMD_NOP;
        bank = 2'b00;
        link_addr = 13'h0000;
        write_mask = 1'b0;
        ctl_dq = 8'hA5;
        #3;
        forever #32 link_ck = ~link_ck;
    end

    // idle lines keep moving
    always @(link_ck) begin
        ctl_dq <= ~ctl_dq;
        write_mask <= ~write_mask;
    end

    task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a, input logic k, input int gap);
        @(negedge link_ck);
        {link_cs_n, link_ras_n, link_cas_n, link_we_n} = c;
        bank = ba;
        link_addr = a;
        link_cke = k;
        repeat (gap) begin
            @(negedge link_ck);
            {link_cs_n, link_ras_n, link_cas_n, link_we_n} = `CMD_NOP;
            link_addr = ~link_addr;
        end
    endtask
endmodule // ddr_ctl_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_cmd_regs.vh"
module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    wire link_ck, link_cke, link_cs_n, link_ras_n, link_cas_n, link_we_n, write_mask;
    wire [1:0] bank;
    wire [12:0] link_addr;
    wire [7:0] ctl_dq, link_dq_out, link_dq_in;
    wire link_dq_oe, link_dqs_out, link_dqs_oe, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'd40, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [33:0] exp_q[$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    // device drive wins the shared data line
    assign link_dq_in = link_dq_oe ? link_dq_out : ctl_dq;
    always #4 mclk = ~mclk;

    ddr_ctl_model ctl (.link_ck(link_ck), .link_cke(link_cke), .link_cs_n(link_cs_n), .link_ras_n(link_ras_n),
        .link_cas_n(link_cas_n), .link_we_n(link_we_n), .bank(bank), .link_addr(link_addr),
        .write_mask(write_mask), .ctl_dq(ctl_dq));
    ddr_cmd_device dut (.mclk(mclk), .srst(srst), .link_ck(link_ck), .link_cke(link_cke), .link_cs_n(link_cs_n),
        .link_ras_n(link_ras_n), .link_cas_n(link_cas_n), .link_we_n(link_we_n), .bank_addr_bit0(bank[0]),
        .bank_addr_bit1(bank[1]), .link_addr(link_addr), .write_mask(write_mask), .link_dq_in(link_dq_in),
        .link_dq_out(link_dq_out), .link_dq_oe(link_dq_oe), .link_dqs_out(link_dqs_out), .link_dqs_oe(link_dqs_oe),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_q.push_back({e, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic link_rd(input logic [1:0] ba, input logic [12:0] a);
        int n;
        n = 0;
        ctl.cmd(`CMD_RD, ba, a, 1'b1, 1);
        while (link_dq_oe !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        chk("dq_oe", 34'h1, {33'h0, link_dq_oe});
        chk("dqs_oe", 34'h1, {33'h0, link_dqs_oe});
        ctl.cmd(`CMD_NOP, 2'b00, 13'h0000, 1'b1, 6);
    endtask

    // answers are compared in order of issue
    always @(posedge mclk) begin
        if (s_axi_bvalid && s_axi_bready) chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        axi_rd(`ADDR_TIMING, {2'b00, 32'h0000C806});
        axi_wr(`ADDR_TIMING, 32'h00000402, 2'b00);
        axi_wr(8'h1C, 32'h00000001, 2'b10);
        axi_rd(8'h1C, {2'b10, 32'h0});
        axi_rd(`ADDR_TIMING, {2'b00, 32'h00000402});
        r = rnd() & 32'h00001FFE;
        ctl.cmd(`CMD_MRS, 2'b00, 13'h0020, 1'b1, 2);
        ctl.cmd(`CMD_MRS, 2'b01, r[12:0], 1'b1, 2);
        ctl.cmd(`CMD_MRS, 2'b10, 13'h1FFF, 1'b1, 2);
        ctl.cmd(4'h8, 2'b00, 13'h1FFF, 1'b1, 2);
        axi_rd(`ADDR_MODE, {2'b00, 32'h00000020});
        axi_rd(`ADDR_EXT_MODE, {2'b00, r});
        ctl.cmd(`CMD_ACT, 2'b01, r[12:0], 1'b1, 3);
        ctl.cmd(`CMD_ACT, 2'b10, 13'h0400, 1'b1, 3);
        axi_rd(`ADDR_STATUS, {2'b00, 32'h00000180});
        ctl.cmd(`CMD_PRE, 2'b10, 13'h0000, 1'b1, 3);
        axi_rd(`ADDR_STATUS, {2'b00, 32'h00000080});
        ctl.cmd(`CMD_PRE, 2'b00, 13'h0400, 1'b1, 3);
        axi_rd(`ADDR_STATUS, 34'h0);
        ctl.cmd(`CMD_ACT, 2'b11, 13'h0000, 1'b1, 3);
        link_rd(2'b11, 13'h0400);
        axi_rd(`ADDR_STATUS, 34'h0);
        ctl.cmd(`CMD_ACT, 2'b00, 13'h0001, 1'b1, 3);
        link_rd(2'b00, 13'h0000);
        axi_rd(`ADDR_STATUS, {2'b00, 32'h00000040});
        ctl.cmd(`CMD_RD, 2'b00, 13'h0000, 1'b1, 1);
        ctl.cmd(`CMD_BST, 2'b00, 13'h0000, 1'b1, 6);
        ctl.cmd(`CMD_PRE, 2'b00, 13'h0400, 1'b1, 3);
        axi_rd(`ADDR_REF_CNT, 34'h0);
        ctl.cmd(`CMD_REF, 2'b11, r[12:0], 1'b1, 4);
        axi_rd(`ADDR_REF_CNT, {2'b00, 32'h00000001});
        ctl.cmd(`CMD_REF, 2'b00, 13'h0000, 1'b0, 4);
        axi_rd(`ADDR_STATUS, {2'b00, 32'h00000003});
        ctl.cmd(`CMD_NOP, 2'b00, 13'h0000, 1'b1, 200);
        axi_rd(`ADDR_STATUS, 34'h0);
        ctl.cmd(`CMD_ACT, 2'b00, 13'h0002, 1'b1, 3);
        ctl.cmd(`CMD_WR, 2'b00, 13'h0400, 1'b1, 8);
        close_out();
    end
endmodule // tb
`default_nettype wire
